// ==== hdl/keypad_map.svh ====
`ifndef KEYPAD_MAP_SVH
`define KEYPAD_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_DEBOUNCE_TIME 8'h22
`define ADDR_DEBOUNCE_ENABLE 8'h24
`define ADDR_SLEEP_SCAN 8'h25
`define ADDR_MATRIX_SIZE 8'h26
`define ADDR_COLUMN_MAP 8'h27
`define ADDR_ROW_MAP 8'h28
`define ADDR_EVENT_STATUS 8'h29
`define ADDR_EVENT_MASK 8'h2A

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define RESET_CONFIG 8'h00
`define RESET_KEY_MAP 8'hFF
`define SLEEP_CODE_MSB 6
`define SLEEP_CODE_LSB 4
`define SCAN_CODE_MSB 2
`define SCAN_CODE_LSB 0
`define ROW_CODE_MSB 5
`define ROW_CODE_LSB 3
`define COL_CODE_MSB 2
`define COL_CODE_LSB 0
`define EVENT_PRESS_BIT 0
`define EVENT_SLEEP_BIT 1

// ****************************************************************
// Timing
// ****************************************************************
`define CLOCK_PERIOD_NS 10
`define OSC_NOMINAL_HZ 2000000
`define TIME_UNIT_NS 500000
`define DEBOUNCE_BASE_UNITS 8'h01
`define SCAN_BASE_UNITS 9'h002
`define SLEEP_BASE_UNITS 15'h0080

`endif

// ==== hdl/keypad_pkg.sv ====
`default_nettype none

package keypad_pkg;

    typedef enum logic [3:0] {
        SCAN_OFF = 4'h1,
        SCANNING = 4'h2,
        KEY_HELD = 4'h4,
        ASLEEP = 4'h8
    } scan_state_type;

endpackage

`default_nettype wire

// ==== hdl/keypad_matrix_scanner.sv ====
// Function
// - Each column input is debounced only while its enable bit is one, and passes straight through otherwise.
// - The engine sleeps after the chosen idle time without a press; code 0 disables it, 1 gives 128ms up to 8s.
// - Each row stays active for 1ms at code 0 doubling up to 128ms at code 7.
// - Row-count code 0 stops scanning and code n scans rows 0 through n.
// - Column-count code n uses columns 0 through n, the pins above the row bank.
// - The column of a detected press is stored active low and reads all ones when empty.
// - The row of a detected press is stored active low with bit k for row k, idle all ones.
// - Column map bit k stands for the k-th column pin.
// - Reading the row map sets both maps to all ones, releases the interrupt line and resumes scanning.
// - Reading the column map alone leaves it unchanged.
// - Debounce time is 0.5ms at code 0 doubling up to 64ms at code 7.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_map.svh"

module keypad_matrix_scanner
    import keypad_pkg::*;
#(
    parameter int unsigned OSC_FREQ_HZ = `OSC_NOMINAL_HZ,
    parameter int unsigned TICK_CYCLES =
        ((`TIME_UNIT_NS / `CLOCK_PERIOD_NS) * (`OSC_NOMINAL_HZ / 1000)) / (OSC_FREQ_HZ / 1000)
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic [7:0] columnIn,
    output logic [7:0] rowOut,
    output logic [7:0] rowOe,
    output logic interruptOutN,
    output logic irq
);

    // ****************************************************************
    // Time base
    // ****************************************************************
    // One tick is 0.5ms scaled by the nominal over the real oscillator rate.
    localparam int unsigned TICK_LIMIT = (TICK_CYCLES < 1) ? 1 : TICK_CYCLES;

    logic [31:0] prescale_q, prescale_d;
    logic tick;

    always_comb
    begin
        tick = (prescale_q == 32'(TICK_LIMIT - 1));
        prescale_d = tick ? 32'h0 : prescale_q + 32'h1;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            prescale_q <= 32'h0;
        else
            prescale_q <= prescale_d;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [2:0] debounceTimeSelect_q, debounceTimeSelect_d;
    logic [7:0] debounceEnable_q, debounceEnable_d;
    logic [7:0] sleepScan_q, sleepScan_d;
    logic [7:0] matrixSize_q, matrixSize_d;
    logic [1:0] eventStatus_q, eventStatus_d;
    logic [1:0] eventMask_q, eventMask_d;
    logic [7:0] rdData_q, rdData_d;
    logic [7:0] columnMap_q, columnMap_d;
    logic [7:0] rowMap_q, rowMap_d;
    logic pressEvent, sleepEvent, rowMapRead;

    always_comb
    begin
        debounceTimeSelect_d = debounceTimeSelect_q;
        debounceEnable_d = debounceEnable_q;
        sleepScan_d = sleepScan_q;
        matrixSize_d = matrixSize_q;
        eventMask_d = eventMask_q;
        eventStatus_d = eventStatus_q;
        if (regWrEn)
        begin
            case (regAddr)
                `ADDR_DEBOUNCE_TIME: debounceTimeSelect_d = regWrData[2:0];
                `ADDR_DEBOUNCE_ENABLE: debounceEnable_d = regWrData;
                `ADDR_SLEEP_SCAN: sleepScan_d = regWrData & 8'h77;
                `ADDR_MATRIX_SIZE: matrixSize_d = regWrData & 8'h3F;
                `ADDR_EVENT_STATUS: eventStatus_d = eventStatus_q & ~regWrData[1:0];
                `ADDR_EVENT_MASK: eventMask_d = regWrData[1:0];
                default: eventMask_d = eventMask_q;
            endcase
        end
        // A new event in the clearing cycle survives the clear.
        eventStatus_d[`EVENT_PRESS_BIT] = eventStatus_d[`EVENT_PRESS_BIT] | pressEvent;
        eventStatus_d[`EVENT_SLEEP_BIT] = eventStatus_d[`EVENT_SLEEP_BIT] | sleepEvent;
        rdData_d = 8'h00;
        if (regRdEn)
        begin
            case (regAddr)
                `ADDR_DEBOUNCE_TIME: rdData_d = {5'h00, debounceTimeSelect_q};
                `ADDR_DEBOUNCE_ENABLE: rdData_d = debounceEnable_q;
                `ADDR_SLEEP_SCAN: rdData_d = sleepScan_q;
                `ADDR_MATRIX_SIZE: rdData_d = matrixSize_q;
                `ADDR_COLUMN_MAP: rdData_d = columnMap_q;
                `ADDR_ROW_MAP: rdData_d = rowMap_q;
                `ADDR_EVENT_STATUS: rdData_d = {6'h00, eventStatus_q};
                `ADDR_EVENT_MASK: rdData_d = {6'h00, eventMask_q};
                default: rdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            debounceTimeSelect_q <= 3'h0;
            debounceEnable_q <= `RESET_CONFIG;
            sleepScan_q <= `RESET_CONFIG;
            matrixSize_q <= `RESET_CONFIG;
            eventStatus_q <= 2'h0;
            eventMask_q <= 2'h0;
            rdData_q <= 8'h00;
        end
        else
        begin
            debounceTimeSelect_q <= debounceTimeSelect_d;
            debounceEnable_q <= debounceEnable_d;
            sleepScan_q <= sleepScan_d;
            matrixSize_q <= matrixSize_d;
            eventStatus_q <= eventStatus_d;
            eventMask_q <= eventMask_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;
    assign irq = |(eventStatus_q & eventMask_q);

    // ****************************************************************
    // Column synchroniser and debouncers
    // ****************************************************************
    logic [7:0] columnMeta_q, columnSync_q, columnDebounced;
    logic [7:0] debounceLimit;

    assign debounceLimit = `DEBOUNCE_BASE_UNITS << debounceTimeSelect_q;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            columnMeta_q <= 8'hFF;
            columnSync_q <= 8'hFF;
        end
        else
        begin
            columnMeta_q <= columnIn;
            columnSync_q <= columnMeta_q;
        end
    end

    for (genvar k = 0; k < 8; k++)
    begin : gDebounce
        logic [7:0] count_q, count_d;
        logic level_q, level_d;

        always_comb
        begin
            count_d = count_q;
            level_d = level_q;
            if (!debounceEnable_q[k])
            begin
                level_d = columnSync_q[k];
                count_d = 8'h00;
            end
            else if (columnSync_q[k] == level_q)
                count_d = 8'h00;
            else if (tick)
            begin
                if (count_q >= 8'(debounceLimit - 8'h01))
                begin
                    level_d = columnSync_q[k];
                    count_d = 8'h00;
                end
                else
                    count_d = count_q + 8'h01;
            end
        end

        always_ff @(posedge clock)
        begin
            if (srst)
            begin
                count_q <= 8'h00;
                level_q <= 1'b1;
            end
            else
            begin
                count_q <= count_d;
                level_q <= level_d;
            end
        end

        assign columnDebounced[k] = level_q;
    end

    // ****************************************************************
    // Scan engine
    // ****************************************************************
    scan_state_type state_q, state_d;
    logic [2:0] rowIdx_q, rowIdx_d;
    logic [8:0] rowTimer_q, rowTimer_d;
    logic [14:0] sleepTimer_q, sleepTimer_d;
    logic [7:0] rowOe_q, rowOe_d;
    logic [2:0] rowCode, colCode, sleepCode;
    logic [8:0] rowLimit;
    logic [14:0] sleepLimit;
    logic [7:0] columnMask, rowMask, columnsLow;
    logic rowDone, sizeWrite;

    always_comb
    begin
        rowCode = matrixSize_q[`ROW_CODE_MSB:`ROW_CODE_LSB];
        colCode = matrixSize_q[`COL_CODE_MSB:`COL_CODE_LSB];
        sleepCode = sleepScan_q[`SLEEP_CODE_MSB:`SLEEP_CODE_LSB];
        rowLimit = `SCAN_BASE_UNITS << sleepScan_q[`SCAN_CODE_MSB:`SCAN_CODE_LSB];
        sleepLimit = `SLEEP_BASE_UNITS << sleepCode;
        columnMask = 8'hFF >> (3'h7 - colCode);
        rowMask = 8'hFF >> (3'h7 - rowCode);
        columnsLow = ~columnDebounced & columnMask;
        rowDone = tick && (rowTimer_q >= 9'(rowLimit - 9'h001));
        rowMapRead = regRdEn && (regAddr == `ADDR_ROW_MAP);
        sizeWrite = regWrEn && (regAddr == `ADDR_MATRIX_SIZE);
    end

    always_comb
    begin
        state_d = state_q;
        rowIdx_d = rowIdx_q;
        rowTimer_d = rowTimer_q;
        sleepTimer_d = sleepTimer_q;
        columnMap_d = columnMap_q;
        rowMap_d = rowMap_q;
        pressEvent = 1'b0;
        sleepEvent = 1'b0;
        // row map read clears both maps
        if (rowMapRead)
        begin
            rowMap_d = `RESET_KEY_MAP;
            columnMap_d = `RESET_KEY_MAP;
        end
        // scanning off at row code zero
        if (rowCode == 3'h0)
        begin
            state_d = SCAN_OFF;
            rowIdx_d = 3'h0;
            rowTimer_d = 9'h000;
            sleepTimer_d = 15'h0000;
        end
        else
        begin
            case (state_q)
                SCAN_OFF:
                begin
                    state_d = SCANNING;
                end
                SCANNING:
                begin
                    if (tick)
                    begin
                        rowTimer_d = rowTimer_q + 9'h001;
                        sleepTimer_d = sleepTimer_q + 15'h0001;
                    end
                    // sample at the end of each row period
                    if (rowDone)
                    begin
                        rowTimer_d = 9'h000;
                        if (columnsLow != 8'h00)
                        begin
                            rowMap_d = ~(8'h01 << rowIdx_q);
                            columnMap_d = ~columnsLow;
                            pressEvent = 1'b1;
                            sleepTimer_d = 15'h0000;
                            state_d = KEY_HELD;
                        end
                        else
                            rowIdx_d = (rowIdx_q >= rowCode) ? 3'h0 : rowIdx_q + 3'h1;
                    end
                    // enter sleep after the idle time
                    else if (tick && sleepCode != 3'h0 && sleepTimer_q >= 15'(sleepLimit - 15'h0001))
                    begin
                        sleepEvent = 1'b1;
                        state_d = ASLEEP;
                    end
                end
                KEY_HELD:
                begin
                    if (rowMapRead)
                    begin
                        state_d = SCANNING;
                        rowIdx_d = 3'h0;
                        rowTimer_d = 9'h000;
                    end
                end
                ASLEEP:
                begin
                    if (columnsLow != 8'h00)
                    begin
                        state_d = SCANNING;
                        rowIdx_d = 3'h0;
                        rowTimer_d = 9'h000;
                        sleepTimer_d = 15'h0000;
                    end
                end
                default:
                begin
                    state_d = SCAN_OFF;
                end
            endcase
            // restart on resize
            // Restarting keeps a row beyond a smaller row count from ever being driven.
            if (sizeWrite && state_d != KEY_HELD)
            begin
                state_d = SCAN_OFF;
                rowIdx_d = 3'h0;
                rowTimer_d = 9'h000;
                sleepTimer_d = 15'h0000;
            end
        end
        // Asleep, the rows within the configured row count pull low so that a press inside the row and column window wakes the engine.
        case (state_d)
            SCANNING: rowOe_d = 8'h01 << rowIdx_d;
            ASLEEP: rowOe_d = rowMask;
            default: rowOe_d = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= SCAN_OFF;
            rowIdx_q <= 3'h0;
            rowTimer_q <= 9'h000;
            sleepTimer_q <= 15'h0000;
            columnMap_q <= `RESET_KEY_MAP;
            rowMap_q <= `RESET_KEY_MAP;
            rowOe_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            rowIdx_q <= rowIdx_d;
            rowTimer_q <= rowTimer_d;
            sleepTimer_q <= sleepTimer_d;
            columnMap_q <= columnMap_d;
            rowMap_q <= rowMap_d;
            rowOe_q <= rowOe_d;
        end
    end

    // Rows are open-drain: an enabled row is pulled low, the rest float.
    assign rowOut = 8'h00;
    assign rowOe = rowOe_q;
    assign interruptOutN = (state_q != KEY_HELD);

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    AST_SCAN_OFF: assert property ((rowCode == 3'h0) |=> (state_q == SCAN_OFF && rowOe == 8'h00))
        else $error("Scanning did not stop at row code zero.");
    AST_ROW_RANGE: assert property ((state_q == SCANNING) |-> ((rowOe & ~rowMask) == 8'h00))
        else $error("A row outside the configured count was driven.");
    AST_ONE_ROW: assert property ((state_q == SCANNING) |-> $onehot(rowOe))
        else $error("Scanning did not drive exactly one row.");
    AST_HELD_MAP: assert property ((state_q == KEY_HELD) |-> (rowMap_q != 8'hFF && !interruptOutN))
        else $error("Held press without a row map or interrupt.");
    AST_ROW_READ: assert property ((rowMapRead && state_q == KEY_HELD) |=>
        (rowMap_q == 8'hFF && columnMap_q == 8'hFF && interruptOutN && state_q == SCANNING))
        else $error("Row map read did not clear and resume.");
    AST_COL_READ: assert property ((regRdEn && regAddr == `ADDR_COLUMN_MAP && state_q == KEY_HELD)
        |=> $stable(columnMap_q))
        else $error("Column map read changed the column map.");
    AST_BYPASS: assert property ((!debounceEnable_q[0] && !$past(debounceEnable_q[0])) |->
        (columnDebounced[0] == $past(columnSync_q[0])))
        else $error("Undebounced column did not follow its input.");
    AST_NO_SLEEP: assert property ((sleepCode == 3'h0 && state_q != ASLEEP) |=> (state_q != ASLEEP))
        else $error("Engine slept with auto-sleep off.");
    AST_ROW_STEP: assert property ((state_q == SCANNING && $past(state_q) == SCANNING && $changed(rowIdx_q))
        |-> $past(rowDone))
        else $error("Row advanced before its period ended.");
    AST_MAP_ONEHOT: assert property ((state_q == KEY_HELD) |-> $onehot(~rowMap_q))
        else $error("Row map does not name exactly one row.");

    COV_PRESS: cover property (state_q == SCANNING ##1 state_q == KEY_HELD);
    COV_RESUME: cover property (state_q == KEY_HELD ##1 state_q == SCANNING);
    COV_SLEEP: cover property (state_q == ASLEEP ##1 state_q == SCANNING);

endmodule

`default_nettype wire

// ==== tb/keypad_matrix_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Switch matrix with a pull-up on every column
// ****************************************************************
module keypad_matrix_model
(
    input wire logic [7:0] rowOe,
    input wire logic [63:0] keyDown,
    output logic [7:0] columnIn
);
    // A column only goes low through a closed key on a row that is driven low.
    // Otherwise the pull-up takes it high, so no stale level is left behind.
    always_comb
    begin
        columnIn = 8'hFF;
        for (int r = 0; r < 8; r++)
        begin
            for (int c = 0; c < 8; c++)
            begin
                if (rowOe[r] && keyDown[r * 8 + c])
                begin
                    columnIn[c] = 1'b0;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int Tick = 4;
    localparam int Limit = 40000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData, columnIn, rowOut, rowOe;
    logic interruptOutN, irq;
    logic [63:0] keyDown = 64'h0;
    logic rdPending = 1'b0;
    logic [7:0] expQ[$];
    string nameQ[$];
    int failCount = 0;
    int testsRun = 0;
    int cycles = 0;

    always #5 clock = ~clock;

    keypad_matrix_scanner #(.TICK_CYCLES(Tick)) dut_u (.clock(clock), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .columnIn(columnIn), .rowOut(rowOut), .rowOe(rowOe), .interruptOutN(interruptOutN), .irq(irq));

    keypad_matrix_model partner_u (.rowOe(rowOe), .keyDown(keyDown), .columnIn(columnIn));

    task automatic check(input string what, input logic [7:0] expV, input logic [7:0] got);
        testsRun++;
        if (got !== expV)
        begin
            failCount++;
            $display("unexpected %s: expected %h, seen %h", what, expV, got);
        end
    endtask

    task automatic summarize;
        $display("Checks run %0d, mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // Result watcher and hang limit
    // ****************************************************************
    always @(posedge clock)
    begin
        rdPending <= regRdEn;
        if (rdPending)
            check(nameQ.pop_front(), expQ.pop_front(), regRdData);
        cycles++;
        if (cycles == Limit)
        begin
            failCount++;
            $display("unexpected run length: expected below %0d cycles, seen %0d", Limit, cycles);
            summarize();
        end
    end

    // ****************************************************************
    // Bus and wait helpers
    // ****************************************************************
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clock);
        regWrEn <= 1'b0;
    endtask

    task automatic regRead(input logic [7:0] a, input logic [7:0] expV, input string what);
        expQ.push_back(expV);
        nameQ.push_back(what);
        @(posedge clock);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clock);
        regRdEn <= 1'b0;
    endtask

    task automatic setKeys(input logic [63:0] k);
        @(posedge clock);
        keyDown <= k;
    endtask

    task automatic waitIrqN(input logic want, input int limit);
        int n;
        n = 0;
        while (interruptOutN !== want && n < limit)
        begin
            @(negedge clock);
            n++;
        end
        check("interrupt line", {7'h00, want}, {7'h00, interruptOutN});
    endtask

    task automatic waitRows(input logic [7:0] want);
        int n;
        n = 0;
        while (rowOe !== want && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic scanPeriod(input logic [2:0] code);
        int n;
        n = 0;
        regWrite(8'h25, {5'b00000, code});
        waitRows(8'h02);
        waitRows(8'h01);
        while (rowOe === 8'h01 && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
        check("row period", 8'(8 << code), n[7:0]);
        check("second row", 8'h02, rowOe);
    endtask

    task automatic pressCase(input logic [2:0] rc, input logic [2:0] cc, input int r, input int c);
        logic [7:0] colExp;
        logic [7:0] rowExp;
        colExp = ~(8'h01 << c);
        rowExp = ~(8'h01 << r);
        regWrite(8'h26, {2'b00, rc, cc});
        setKeys(64'h1 << (r * 8 + c));
        waitIrqN(1'b0, 3000);
        check("press irq", 8'h01, {7'h00, irq});
        regRead(8'h27, colExp, "column map");
        regRead(8'h27, colExp, "column map again");
        setKeys(64'h0);
        regRead(8'h28, rowExp, "row map");
        repeat (2) @(posedge clock);
        check("interrupt after row read", 8'h01, {7'h00, interruptOutN});
        regRead(8'h27, 8'hFF, "column map cleared");
        regWrite(8'h29, 8'h01);
        repeat (2) @(posedge clock);
        check("irq cleared", 8'h00, {7'h00, irq});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [7:0] v;
        logic [2:0] rc;
        logic [2:0] cc;
        void'($urandom(39755));
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        regRead(8'h22, 8'h00, "debounce time reset");
        regRead(8'h24, 8'h00, "debounce enable reset");
        regRead(8'h25, 8'h00, "sleep scan reset");
        regRead(8'h26, 8'h00, "matrix size reset");
        regRead(8'h27, 8'hFF, "column map reset");
        regRead(8'h28, 8'hFF, "row map reset");
        regRead(8'h30, 8'h00, "unmapped read");
        v = 8'($urandom);
        regWrite(8'h24, v);
        regRead(8'h24, v, "debounce enable");
        regWrite(8'h25, v);
        regRead(8'h25, v & 8'h77, "sleep scan");
        regWrite(8'h22, v);
        regRead(8'h22, v & 8'h07, "debounce time");
        regWrite(8'h27, 8'h00);
        regWrite(8'h30, v);
        regRead(8'h27, 8'hFF, "column map write");
        regRead(8'h30, 8'h00, "unmapped after write");
        regWrite(8'h22, 8'h00);
        regWrite(8'h24, 8'h00);
        regWrite(8'h25, 8'h00);
        regWrite(8'h2A, 8'h01);
        setKeys(64'h1);
        repeat (300) @(posedge clock);
        check("rows while off", 8'h00, rowOe);
        check("interrupt while off", 8'h01, {7'h00, interruptOutN});
        setKeys(64'h0);
        pressCase(3'h7, 3'h7, 7, 7);
        pressCase(3'h1, 3'h0, 1, 0);
        for (int i = 0; i < 4; i++)
        begin
            rc = 3'($urandom_range(7, 1));
            cc = 3'($urandom_range(7, 0));
            pressCase(rc, cc, $urandom_range(rc, 0), $urandom_range(cc, 0));
        end
        regWrite(8'h26, 8'h1A);
        setKeys(64'h1 << 5);
        repeat (500) @(posedge clock);
        check("column outside window", 8'h01, {7'h00, interruptOutN});
        setKeys(64'h0);
        regWrite(8'h26, 8'h08);
        scanPeriod(3'h0);
        scanPeriod(3'h2);
        scanPeriod(3'h4);
        regWrite(8'h22, 8'h02);
        regWrite(8'h24, 8'hFF);
        // Row time above debounce time.
        regWrite(8'h25, 8'h03);
        waitRows(8'h02);
        waitRows(8'h01);
        repeat (58) @(negedge clock);
        setKeys(64'h101);
        repeat (8) @(posedge clock);
        setKeys(64'h0);
        repeat (300) @(posedge clock);
        check("short glitch", 8'h01, {7'h00, interruptOutN});
        setKeys(64'h100);
        waitIrqN(1'b0, 3000);
        setKeys(64'h0);
        regRead(8'h28, 8'hFD, "debounced row map");
        regWrite(8'h29, 8'h01);
        regWrite(8'h2A, 8'h00);
        regWrite(8'h26, 8'h00);
        regWrite(8'h25, 8'h13);
        regWrite(8'h26, 8'h08);
        repeat (900) @(posedge clock);
        regRead(8'h29, 8'h00, "status before sleep");
        repeat (250) @(posedge clock);
        regRead(8'h29, 8'h02, "status after sleep");
        repeat (2) @(negedge clock);
        check("rows while asleep", 8'h03, rowOe);
        check("row output level", 8'h00, rowOut);
        check("masked irq", 8'h00, {7'h00, irq});
        regWrite(8'h2A, 8'h02);
        repeat (2) @(posedge clock);
        check("unmasked irq", 8'h01, {7'h00, irq});
        regWrite(8'h29, 8'h02);
        repeat (2) @(posedge clock);
        check("status cleared irq", 8'h00, {7'h00, irq});
        setKeys(64'h100);
        waitIrqN(1'b0, 3000);
        setKeys(64'h0);
        regRead(8'h28, 8'hFD, "row map after wake");
        repeat (4) @(posedge clock);
        summarize();
    end
endmodule

`default_nettype wire
